// ### design/brk_status_pkg.sv
package brk_status_pkg;

	// clock and time base
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_TIME_MS  = 1;
	// one millisecond of clock cycles, rounded down (a longest time)
	localparam int TICK_CYCLES   = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;

	// widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int VOLT_W = 16;
	localparam int TIME_W = 16;
	localparam int POLES  = 6;
	localparam int PIN_W  = 21;

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_IN_FLAGS   = 8'h04;
	localparam logic [7:0] ADDR_VOLT_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_POLE_FLAGS = 8'h0c;
	localparam logic [7:0] ADDR_BRK_FLAGS  = 8'h10;
	localparam logic [7:0] ADDR_TRIG       = 8'h14;
	localparam logic [7:0] ADDR_MAX_OPEN   = 8'h18;
	localparam logic [7:0] ADDR_MAX_CLOSE  = 8'h1c;
	localparam logic [7:0] ADDR_THR_BASE   = 8'h20;
	localparam logic [7:0] ADDR_THR_LAST   = 8'h3c;

	// control register fields
	localparam int CTRL_TABLE_LSB = 0;
	localparam int CTRL_TRIG_BIT  = 8;

	// reset values
	localparam logic [1:0]        RST_ACTIVE_TABLE = 2'h1;
	localparam logic [TIME_W-1:0] RST_MAX_OPEN     = 16'h0064;
	localparam logic [TIME_W-1:0] RST_MAX_CLOSE    = 16'h0064;
	localparam logic [VOLT_W-1:0] RST_DEAD_THR     = 16'h0100;
	localparam logic [VOLT_W-1:0] RST_LIVE_THR     = 16'h0800;

	// pin bit positions inside the synchronised vector
	localparam int PIN_POLE_B   = 0;  // 6 open (52b-type) contacts
	localparam int PIN_POLE_A   = 6;  // 6 closed (52a-type) contacts
	localparam int PIN_FP_TRIG  = 12;
	localparam int PIN_CLOSE_OK = 13; // 2 bits
	localparam int PIN_RECL_OK  = 15; // 2 bits
	localparam int PIN_RI_3P    = 17;
	localparam int PIN_RI_1P    = 18;
	localparam int PIN_LOCKOUT  = 19;
	localparam int PIN_TABLE    = 20; // table select uses bits 20 and 21
	localparam int PIN_ALL      = PIN_W + 1;

	// per-pole transition supervision
	typedef enum logic [2:0] {
		POLE_IDLE    = 3'b001,
		POLE_OPENING = 3'b010,
		POLE_CLOSING = 3'b100
	} pole_phase_e;

endpackage : brk_status_pkg

// ### design/breaker_status_monitor.sv
`timescale 1ns/1ps
module breaker_status_monitor
	import brk_status_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	// digital input pins
	input  wire logic [1:0]        table_sel_in,
	input  wire logic              lockout_in,
	input  wire logic              ri_1p_in,
	input  wire logic              ri_3p_in,
	input  wire logic [1:0]        reclose_perm_in,
	input  wire logic [1:0]        close_perm_in,
	input  wire logic              front_panel_trig_in,
	// pole auxiliary contacts, index 0..2 brk1 a-c, 3..5 brk2 a-c
	input  wire logic [POLES-1:0]  pole_a_contact_in,
	input  wire logic [POLES-1:0]  pole_b_contact_in,
	// pole commands per breaker, from on-chip trip/close logic
	input  wire logic [1:0]        open_cmd,
	input  wire logic [1:0]        close_cmd,
	// measured voltages, on-chip samples
	input  wire logic [VOLT_W-1:0] volt_line1,
	input  wire logic [VOLT_W-1:0] volt_bus1,
	input  wire logic [VOLT_W-1:0] volt_line2,
	input  wire logic [VOLT_W-1:0] volt_bus2,
	// results of other on-chip functions
	input  wire logic [1:0]        sync_reclose_conditions,
	input  wire logic [1:0]        manual_close_conditions,
	input  wire logic [1:0]        pole_disagree_trip,
	// mirrored and derived flags
	output logic      [2:0]        table_active,
	output logic                   comm_trigger,
	output logic                   lockout_flag,
	output logic                   ri_1p_flag,
	output logic                   ri_3p_flag,
	output logic      [3:0]        dead_flag,
	output logic      [3:0]        live_flag,
	output logic      [1:0]        ext_reclose_en,
	output logic      [1:0]        ext_close_en,
	output logic      [1:0]        int_reclose_en,
	output logic      [1:0]        int_close_en,
	// pole flags
	output logic      [POLES-1:0]  pole_closed,
	output logic      [POLES-1:0]  pole_undef,
	output logic      [POLES-1:0]  pole_fail_open,
	output logic      [POLES-1:0]  pole_fail_close,
	// breaker aggregates, bit 0 breaker 1, bit 1 breaker 2
	output logic      [1:0]        brk_disagree,
	output logic      [1:0]        brk_undef,
	output logic      [1:0]        brk_fail_open,
	output logic      [1:0]        brk_fail_close,
	output logic      [1:0]        brk_all_open,
	output logic      [1:0]        brk_two_open,
	output logic      [1:0]        brk_one_open,
	output logic      [1:0]        brk_all_closed
);

	// number of set bits among three
	function automatic logic [1:0] count3(input logic [2:0] v);
		count3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
	endfunction : count3

	// unsigned compare, shared by all threshold checks
	function automatic logic below(input logic [VOLT_W-1:0] v,
		input logic [VOLT_W-1:0] thr);
		below = v < thr;
	endfunction : below

	// pin synchroniser: three stages, change accepted when 2 and 3 agree
	wire  [PIN_ALL-1:0] pin_raw;
	logic [PIN_ALL-1:0] pin_s1;
	logic [PIN_ALL-1:0] pin_s2;
	logic [PIN_ALL-1:0] pin_s3;
	logic [PIN_ALL-1:0] pin_q;
	wire  [PIN_ALL-1:0] next_pin_q;

	assign pin_raw = {table_sel_in, lockout_in, ri_1p_in, ri_3p_in,
		reclose_perm_in, close_perm_in, front_panel_trig_in,
		pole_a_contact_in, pole_b_contact_in};
	// a bit moves only once stages 2 and 3 agree, filtering one-cycle glitches
	assign next_pin_q = (pin_s2 & pin_s3) | (pin_q & (pin_s2 | pin_s3));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
			pin_q  <= '0;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_q  <= next_pin_q;
		end
	end

	// registered copies of same-clock inputs
	logic [VOLT_W-1:0] v_q [4];
	logic [1:0]        sync_q;
	logic [1:0]        manual_q;
	logic [1:0]        disagree_q;
	logic [1:0]        open_cmd_q;
	logic [1:0]        close_cmd_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			v_q         <= '{default: '0};
			sync_q      <= '0;
			manual_q    <= '0;
			disagree_q  <= '0;
			open_cmd_q  <= '0;
			close_cmd_q <= '0;
		end else begin
			v_q[0]      <= volt_line1;
			v_q[1]      <= volt_bus1;
			v_q[2]      <= volt_line2;
			v_q[3]      <= volt_bus2;
			sync_q      <= sync_reclose_conditions;
			manual_q    <= manual_close_conditions;
			disagree_q  <= pole_disagree_trip;
			open_cmd_q  <= open_cmd;
			close_cmd_q <= close_cmd;
		end
	end

	// settings registers
	logic [1:0]        active_table;
	logic [TIME_W-1:0] max_opening_time;
	logic [TIME_W-1:0] max_closing_time;
	// order: line1, bus1, line2, bus2 dead then live
	logic [VOLT_W-1:0] dead_thr [4];
	logic [VOLT_W-1:0] live_thr [4];
	logic              trig_sticky;

	// register decode
	wire       wr_ctrl  = reg_wr && reg_addr == ADDR_CTRL;
	wire       wr_trig  = reg_wr && reg_addr == ADDR_TRIG;
	wire       wr_mopen = reg_wr && reg_addr == ADDR_MAX_OPEN;
	wire       wr_mclos = reg_wr && reg_addr == ADDR_MAX_CLOSE;
	wire       thr_hit  = reg_addr >= ADDR_THR_BASE &&
		reg_addr <= ADDR_THR_LAST && reg_addr[1:0] == 2'h0;
	wire [2:0] thr_idx  = reg_addr[4:2];
	wire       wr_thr   = reg_wr && thr_hit;

	// trigger events: host write to control, or keypad edge
	wire fp_rise   = next_pin_q[PIN_FP_TRIG] & ~pin_q[PIN_FP_TRIG];
	wire host_trig = wr_ctrl & reg_wdata[CTRL_TRIG_BIT];
	wire trig_evt  = host_trig | fp_rise;
	// write-one-to-clear; a trigger in the same cycle wins
	wire next_trig = trig_evt |
		(trig_sticky & ~(wr_trig & reg_wdata[0]));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			active_table     <= RST_ACTIVE_TABLE;
			max_opening_time <= RST_MAX_OPEN;
			max_closing_time <= RST_MAX_CLOSE;
			dead_thr         <= '{default: RST_DEAD_THR};
			live_thr         <= '{default: RST_LIVE_THR};
			trig_sticky      <= 1'b0;
		end else begin
			if (wr_ctrl)
				active_table <= reg_wdata[CTRL_TABLE_LSB +: 2];
			if (wr_mopen)
				max_opening_time <= reg_wdata[TIME_W-1:0];
			if (wr_mclos)
				max_closing_time <= reg_wdata[TIME_W-1:0];
			if (wr_thr && !thr_idx[2])
				dead_thr[thr_idx[1:0]] <= reg_wdata[VOLT_W-1:0];
			if (wr_thr && thr_idx[2])
				live_thr[thr_idx[1:0]] <= reg_wdata[VOLT_W-1:0];
			trig_sticky <= next_trig;
		end
	end

	// active table: inputs win, setting used when all are de-energised
	wire [1:0] tsel       = pin_q[PIN_TABLE +: 2];
	wire [1:0] table_code = (tsel == 2'h0) ? active_table : tsel;
	wire [2:0] next_table = {table_code == 2'h3, table_code == 2'h2,
		table_code == 2'h1};

	// voltage level detection
	logic [3:0] next_dead;
	logic [3:0] next_live;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			next_dead[i] = below(v_q[i], dead_thr[i]);
			next_live[i] = below(live_thr[i], v_q[i]);
		end
	end

	// pole state from the two auxiliary contacts
	wire [POLES-1:0] pa          = pin_q[PIN_POLE_A +: POLES];
	wire [POLES-1:0] pb          = pin_q[PIN_POLE_B +: POLES];
	wire [POLES-1:0] now_closed  = pa & ~pb;
	wire [POLES-1:0] now_open    = ~pa & pb;
	// both made or both broken: position unknown
	wire [POLES-1:0] now_undef   = ~(pa ^ pb);

	// ms tick for the transition timers
	logic [31:0] tick_cnt;
	wire         tick = tick_cnt == 32'(TICK_CYC - 1);

	always_ff @(posedge clk) begin
		if (!rst_n)
			tick_cnt <= '0;
		else
			tick_cnt <= tick ? '0 : tick_cnt + 32'h1;
	end

	// per-pole transition supervision
	pole_phase_e       phase      [POLES];
	pole_phase_e       next_phase [POLES];
	logic [TIME_W-1:0] tmr        [POLES];
	logic [POLES-1:0]  was_closed;
	logic [POLES-1:0]  f_open;
	logic [POLES-1:0]  f_close;
	logic [POLES-1:0]  next_f_open;
	logic [POLES-1:0]  next_f_close;

	always_comb begin
		for (int p = 0; p < POLES; p++) begin
			logic ocmd;
			logic ccmd;
			ocmd = open_cmd_q[p / 3];
			ccmd = close_cmd_q[p / 3];
			next_phase[p]   = phase[p];
			next_f_open[p]  = f_open[p];
			next_f_close[p] = f_close[p];
			case (phase[p])
			POLE_IDLE: begin
				// change begins: command, or contact leaves its position
				if (was_closed[p] && (ocmd || !now_closed[p]))
					next_phase[p] = POLE_OPENING;
				else if (!was_closed[p] && (ccmd || !now_open[p]))
					next_phase[p] = POLE_CLOSING;
			end
			POLE_OPENING: begin
				if (now_open[p]) begin
					next_phase[p]  = POLE_IDLE;
					next_f_open[p] = 1'b0;
				end else if (now_closed[p] && !ocmd) begin
					next_phase[p] = POLE_IDLE;  // bounced back
				end else if (tmr[p] > max_opening_time) begin
					next_f_open[p] = 1'b1;
				end
			end
			POLE_CLOSING: begin
				if (now_closed[p]) begin
					next_phase[p]   = POLE_IDLE;
					next_f_close[p] = 1'b0;
				end else if (now_open[p] && !ccmd) begin
					next_phase[p] = POLE_IDLE;
				end else if (tmr[p] > max_closing_time) begin
					next_f_close[p] = 1'b1;
				end
			end
			default: next_phase[p] = POLE_IDLE;
			endcase
		end
	end

	// timers count ms while a transition is under way, saturating
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phase      <= '{default: POLE_IDLE};
			tmr        <= '{default: '0};
			was_closed <= '0;
			f_open     <= '0;
			f_close    <= '0;
		end else begin
			phase   <= next_phase;
			f_open  <= next_f_open;
			f_close <= next_f_close;
			for (int p = 0; p < POLES; p++) begin
				if (next_phase[p] == POLE_IDLE)
					tmr[p] <= '0;
				else if (tick && tmr[p] != '1)
					tmr[p] <= tmr[p] + 16'h1;
				// remember the last defined position only
				if (!now_undef[p])
					was_closed[p] <= now_closed[p];
			end
		end
	end

	// breaker aggregates; one function serves both breakers
	wire [1:0] open_cnt1 = count3(now_open[2:0]);
	wire [1:0] open_cnt2 = count3(now_open[5:3]);

	wire [1:0] next_b_undef = {|now_undef[5:3], |now_undef[2:0]};
	wire [1:0] next_b_fo    = {|next_f_open[5:3],
		|next_f_open[2:0]};
	wire [1:0] next_b_fc    = {|next_f_close[5:3],
		|next_f_close[2:0]};
	wire [1:0] next_b_all_o = {open_cnt2 == 2'h3,
		open_cnt1 == 2'h3};
	wire [1:0] next_b_two_o = {open_cnt2 == 2'h2,
		open_cnt1 == 2'h2};
	wire [1:0] next_b_one_o = {open_cnt2 == 2'h1,
		open_cnt1 == 2'h1};
	wire [1:0] next_b_all_c = {&now_closed[5:3],
		&now_closed[2:0]};

	// every output flag is a flop, updated each cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			table_active    <= '0;
			comm_trigger    <= 1'b0;
			lockout_flag    <= 1'b0;
			ri_1p_flag      <= 1'b0;
			ri_3p_flag      <= 1'b0;
			dead_flag       <= '0;
			live_flag       <= '0;
			ext_reclose_en  <= '0;
			ext_close_en    <= '0;
			int_reclose_en  <= '0;
			int_close_en    <= '0;
			pole_closed     <= '0;
			pole_undef      <= '0;
			pole_fail_open  <= '0;
			pole_fail_close <= '0;
			brk_disagree    <= '0;
			brk_undef       <= '0;
			brk_fail_open   <= '0;
			brk_fail_close  <= '0;
			brk_all_open    <= '0;
			brk_two_open    <= '0;
			brk_one_open    <= '0;
			brk_all_closed  <= '0;
		end else begin
			table_active    <= next_table;
			comm_trigger    <= next_trig;
			lockout_flag    <= next_pin_q[PIN_LOCKOUT];
			ri_1p_flag      <= next_pin_q[PIN_RI_1P];
			ri_3p_flag      <= next_pin_q[PIN_RI_3P];
			dead_flag       <= next_dead;
			live_flag       <= next_live;
			ext_reclose_en  <= next_pin_q[PIN_RECL_OK +: 2];
			ext_close_en    <= next_pin_q[PIN_CLOSE_OK +: 2];
			int_reclose_en  <= sync_q;
			int_close_en    <= manual_q;
			pole_closed     <= now_closed;
			pole_undef      <= now_undef;
			pole_fail_open  <= next_f_open;
			pole_fail_close <= next_f_close;
			brk_disagree    <= disagree_q;
			brk_undef       <= next_b_undef;
			brk_fail_open   <= next_b_fo;
			brk_fail_close  <= next_b_fc;
			brk_all_open    <= next_b_all_o;
			brk_two_open    <= next_b_two_o;
			brk_one_open    <= next_b_one_o;
			brk_all_closed  <= next_b_all_c;
		end
	end

	// read mux; unmapped addresses read zero
	logic [DATA_W-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		case (reg_addr)
		ADDR_CTRL:       rd_mux = {30'h0, active_table};
		ADDR_IN_FLAGS:   rd_mux = {17'h0, int_close_en, int_reclose_en,
			ext_close_en, ext_reclose_en, ri_3p_flag, ri_1p_flag,
			lockout_flag, comm_trigger, table_active};
		ADDR_VOLT_FLAGS: rd_mux = {24'h0, live_flag, dead_flag};
		ADDR_POLE_FLAGS: rd_mux = {8'h0, pole_fail_close, pole_fail_open,
			pole_undef, pole_closed};
		ADDR_BRK_FLAGS:  rd_mux = {16'h0, brk_all_closed, brk_one_open,
			brk_two_open, brk_all_open, brk_fail_close, brk_fail_open,
			brk_undef, brk_disagree};
		ADDR_TRIG:       rd_mux = {31'h0, trig_sticky};
		ADDR_MAX_OPEN:   rd_mux = {16'h0, max_opening_time};
		ADDR_MAX_CLOSE:  rd_mux = {16'h0, max_closing_time};
		default: begin
			if (thr_hit)
				rd_mux = {16'h0, thr_idx[2] ? live_thr[thr_idx[1:0]]
					: dead_thr[thr_idx[1:0]]};
		end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_n)
			reg_rdata <= '0;
		else
			reg_rdata <= reg_rd ? rd_mux : '0;
	end

endmodule : breaker_status_monitor

// ### dv/breaker_status_monitor_props.sv
`timescale 1ns/1ps
module brk_status_checker
	import brk_status_pkg::*;
(
	// clock and reset
	input wire logic              clk,
	input wire logic              rst_n,
	// inputs watched
	input wire logic              lockout_in,
	input wire logic [VOLT_W-1:0] volt_bus1,
	input wire logic [VOLT_W-1:0] volt_line2,
	input wire logic [1:0]        sync_reclose_conditions,
	input wire logic [1:0]        pole_disagree_trip,
	input wire logic [POLES-1:0]  pole_a_contact_in,
	input wire logic [POLES-1:0]  pole_b_contact_in,
	// flags
	input wire logic              lockout_flag,
	input wire logic [3:0]        dead_flag,
	input wire logic [3:0]        live_flag,
	input wire logic [1:0]        int_reclose_en,
	input wire logic [POLES-1:0]  pole_closed,
	input wire logic [POLES-1:0]  pole_undef,
	input wire logic [POLES-1:0]  pole_fail_open,
	input wire logic [POLES-1:0]  pole_fail_close,
	input wire logic [1:0]        brk_disagree,
	input wire logic [1:0]        brk_undef,
	input wire logic [1:0]        brk_fail_open,
	input wire logic [1:0]        brk_fail_close,
	input wire logic [1:0]        brk_all_open,
	input wire logic [1:0]        brk_two_open,
	input wire logic [1:0]        brk_one_open,
	input wire logic [1:0]        brk_all_closed
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// pole state is only trusted once the pin pipeline has refilled
	logic [3:0] since_rst;
	always_ff @(posedge clk) begin
		if (!rst_n)
			since_rst <= 4'h0;
		else if (since_rst != 4'hf)
			since_rst <= since_rst + 4'h1;
	end
	// defined-open poles of breaker 1
	wire       settled = (since_rst == 4'hf);
	wire [2:0] op1     = ~pole_closed[2:0] & ~pole_undef[2:0];
	wire [1:0] nop1    = {1'b0, op1[0]} + {1'b0, op1[1]} + {1'b0, op1[2]};

	AST_LOCKOUT_ON: assert property (
		lockout_in [*6] |-> lockout_flag)
		else $error("lockout flag lags input");
	AST_DEAD_ZERO: assert property (
		(volt_bus1 == 16'h0000) [*3] |-> dead_flag[1] && !live_flag[1])
		else $error("bus 1 at zero not dead");
	AST_LIVE_TOP: assert property (
		(volt_line2 == 16'hffff) [*3] |-> live_flag[2] && !dead_flag[2])
		else $error("line 2 at top not live");
	AST_INT_RECL: assert property (
		$stable(sync_reclose_conditions) [*3]
		|-> int_reclose_en == sync_reclose_conditions)
		else $error("internal reclose flag wrong");
	AST_DISAGREE: assert property (
		$rose(pole_disagree_trip[0]) |-> ##2 brk_disagree[0])
		else $error("disagreement flag late");
	AST_POLE_UNDEF: assert property (
		(pole_a_contact_in[0] == pole_b_contact_in[0]) [*6]
		|-> pole_undef[0] && !pole_closed[0])
		else $error("pole undefined not flagged");
	AST_POLE_CLOSED: assert property (
		(pole_a_contact_in[3] && !pole_b_contact_in[3]) [*6]
		|-> pole_closed[3] && !pole_undef[3])
		else $error("pole closed not flagged");
	AST_FOPEN_OR: assert property (
		brk_fail_open == {|pole_fail_open[5:3], |pole_fail_open[2:0]})
		else $error("breaker fail open wrong");
	AST_FCLOSE_OR: assert property (
		brk_fail_close == {|pole_fail_close[5:3], |pole_fail_close[2:0]})
		else $error("breaker fail close wrong");
	AST_UNDEF_OR: assert property (
		(settled && $stable(pole_undef)) [*2]
		|-> brk_undef == {|pole_undef[5:3], |pole_undef[2:0]})
		else $error("breaker undefined wrong");
	AST_COUNT1: assert property (
		(settled && $stable(pole_closed) && $stable(pole_undef)) [*3]
		|-> brk_all_open[0] == (nop1 == 2'h3)
		&& brk_two_open[0] == (nop1 == 2'h2)
		&& brk_one_open[0] == (nop1 == 2'h1)
		&& brk_all_closed[0] == &pole_closed[2:0])
		else $error("breaker 1 pole count wrong");

	// main scenarios reached
	COV_FAIL_OPEN: cover property (brk_fail_open[1]);
	COV_FAIL_CLOSE: cover property (brk_fail_close[0]);
	COV_TWO_OPEN: cover property (brk_two_open[0]);
endmodule : brk_status_checker

bind breaker_status_monitor brk_status_checker u_chk (
	.clk(clk), .rst_n(rst_n), .lockout_in(lockout_in), .volt_bus1(volt_bus1),
	.volt_line2(volt_line2), .sync_reclose_conditions(sync_reclose_conditions),
	.pole_disagree_trip(pole_disagree_trip),
	.pole_a_contact_in(pole_a_contact_in), .pole_b_contact_in(pole_b_contact_in),
	.lockout_flag(lockout_flag), .dead_flag(dead_flag), .live_flag(live_flag),
	.int_reclose_en(int_reclose_en), .pole_closed(pole_closed),
	.pole_undef(pole_undef), .pole_fail_open(pole_fail_open),
	.pole_fail_close(pole_fail_close), .brk_disagree(brk_disagree),
	.brk_undef(brk_undef), .brk_fail_open(brk_fail_open),
	.brk_fail_close(brk_fail_close), .brk_all_open(brk_all_open),
	.brk_two_open(brk_two_open), .brk_one_open(brk_one_open),
	.brk_all_closed(brk_all_closed)
);

// ### dv/pole_contacts_model.sv
`timescale 1ns/1ps
module pole_contacts_model (
	// clock
	input  wire logic       clk,
	// wanted pole state, stuck poles, travel length
	input  wire logic [5:0] want_closed,
	input  wire logic [5:0] stuck,
	input  wire logic [3:0] travel,
	// auxiliary contacts
	output logic      [5:0] a_contact,
	output logic      [5:0] b_contact
);
	logic [5:0] is_closed = 6'h00;
	logic [3:0] left [6] = '{default: 4'h0};
	wire  [5:0] moving    = ~stuck & (want_closed ^ is_closed);
	// a stuck pole never leaves its old state, as a jammed mechanism would
	always @(posedge clk) begin
		for (int i = 0; i < 6; i++) begin
			if (!moving[i])
				left[i] <= travel;
			else if (left[i] == 4'h0)
				is_closed[i] <= want_closed[i];
			else
				left[i] <= left[i] - 4'h1;
		end
	end
	// both contacts apart in transit, so the pole reads undefined
	assign a_contact = is_closed & ~moving;
	assign b_contact = ~is_closed & ~moving;
endmodule : pole_contacts_model

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top import brk_status_pkg::*;;
	logic              clk = 1'b0, rst_n = 1'b0, fp_trig = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 8'h00;
	logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata;
	logic              reg_wr = 1'b0, reg_rd = 1'b0, lock_in = 1'b0;
	logic              ri1_in = 1'b0, ri3_in = 1'b0, comm_trigger, lock_f;
	logic              ri1_f, ri3_f;
	logic [1:0]        tsel = 2'h0, rperm = 2'h0, cperm = 2'h0;
	logic [1:0]        open_cmd = 2'h0, close_cmd = 2'h0, disagree = 2'h0;
	logic [1:0]        sync_c = 2'h0, man_c = 2'h0, ext_re, ext_ce, int_re;
	logic [1:0]        int_ce, brk_dis, brk_un, brk_fo, brk_fc, brk_ao;
	logic [1:0]        brk_to, brk_oo, brk_ac;
	logic [15:0]       v_l1 = 16'h0, v_b1 = 16'h0, v_l2 = 16'h0, v_b2 = 16'h0;
	logic [5:0]        want = 6'h00, stuck = 6'h00, pa, pb;
	logic [5:0]        pole_cl, pole_un, pole_fo, pole_fc;
	logic [3:0]        travel = 4'h5, dead_f, live_f;
	logic [2:0]        table_active;
	int                fail_count = 0, num_checks = 0, cycles = 0;
	wire  [10:0]       pin_f = {int_ce, int_re, ext_ce, ext_re, ri3_f, ri1_f,
		lock_f};
	// voltages l1,b1,l2,b2; pins as pin_f; {live, dead} at reset thresholds
	typedef struct packed {
		logic [63:0] volt;
		logic [10:0] pins;
		logic [7:0]  vf;
	} row_s;
	row_s rows [5] = '{
		'{64'h0000_0100_0800_ffff, 11'h000, 8'h81},
		'{64'h00ff_0801_0101_07ff, 11'h7ff, 8'h21},
		'{64'hffff_0000_00ff_0801, 11'h555, 8'h96},
		'{64'h0100_ffff_0000_0000, 11'h2aa, 8'h2c},
		'{64'h0800_00ff_ffff_0100, 11'h001, 8'h42}
	};

	breaker_status_monitor #(.TICK_CYC(4)) DUT (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.table_sel_in(tsel), .lockout_in(lock_in), .ri_1p_in(ri1_in),
		.ri_3p_in(ri3_in), .reclose_perm_in(rperm), .close_perm_in(cperm),
		.front_panel_trig_in(fp_trig), .pole_a_contact_in(pa),
		.pole_b_contact_in(pb), .open_cmd(open_cmd), .close_cmd(close_cmd),
		.volt_line1(v_l1), .volt_bus1(v_b1), .volt_line2(v_l2),
		.volt_bus2(v_b2), .sync_reclose_conditions(sync_c),
		.manual_close_conditions(man_c), .pole_disagree_trip(disagree),
		.table_active(table_active), .comm_trigger(comm_trigger),
		.lockout_flag(lock_f), .ri_1p_flag(ri1_f), .ri_3p_flag(ri3_f),
		.dead_flag(dead_f), .live_flag(live_f), .ext_reclose_en(ext_re),
		.ext_close_en(ext_ce), .int_reclose_en(int_re), .int_close_en(int_ce),
		.pole_closed(pole_cl), .pole_undef(pole_un), .pole_fail_open(pole_fo),
		.pole_fail_close(pole_fc), .brk_disagree(brk_dis), .brk_undef(brk_un),
		.brk_fail_open(brk_fo), .brk_fail_close(brk_fc), .brk_all_open(brk_ao),
		.brk_two_open(brk_to), .brk_one_open(brk_oo), .brk_all_closed(brk_ac)
	);
	pole_contacts_model u_poles (
		.clk(clk), .want_closed(want), .stuck(stuck), .travel(travel),
		.a_contact(pa), .b_contact(pb)
	);

	// free-running clock and hang guard
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	// one-cycle strobes, changed right after the edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask : rd
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			@(posedge clk);
			{v_l1, v_b1, v_l2, v_b2} <= rows[i].volt;
			{man_c, sync_c, cperm, rperm, ri3_in, ri1_in, lock_in} <= rows[i].pins;
			repeat (6) @(posedge clk);
			#1 check({live_f, dead_f}, rows[i].vf);
			check(pin_f, rows[i].pins);
		end
		// flag words as the last row left them
		rd(ADDR_VOLT_FLAGS, 32'h42);
		rd(ADDR_IN_FLAGS, 32'h11);
		// settings after reset; an unmapped word reads zero
		rd(ADDR_MAX_OPEN, 32'h64);
		rd(ADDR_MAX_CLOSE, 32'h64);
		rd(ADDR_THR_BASE, 32'h100);
		rd(8'h30, 32'h800);
		rd(8'hfc, 32'h0);
		// table flags from the setting while the select pins rest, then from the select pins
		for (int k = 1; k <= 3; k++) begin
			wr(ADDR_CTRL, k);
			repeat (3) @(posedge clk);
			#1 check(table_active, 1 << (k - 1));
		end
		tsel <= 2'h2;
		repeat (6) @(posedge clk);
		#1 check(table_active, 3'h2);
		tsel <= 2'h0;
		// written dead threshold, both sides of the boundary
		wr(ADDR_THR_BASE, 32'h200);
		v_l1 <= 16'h01ff;
		repeat (3) @(posedge clk);
		#1 check(dead_f[0], 1'b1);
		v_l1 <= 16'h0200;
		repeat (3) @(posedge clk);
		#1 check(dead_f[0], 1'b0);
		// host trigger, clear, then keypad trigger
		wr(ADDR_CTRL, 32'h101);
		repeat (2) @(posedge clk);
		#1 check(comm_trigger, 1'b1);
		wr(ADDR_TRIG, 32'h1);
		repeat (2) @(posedge clk);
		#1 check(comm_trigger, 1'b0);
		fp_trig <= 1'b1;
		repeat (8) @(posedge clk);
		#1 check(comm_trigger, 1'b1);
		disagree <= 2'h1;
		repeat (3) @(posedge clk);
		#1 check(brk_dis, 2'h1);
		// close both breakers; poles read undefined while travelling
		close_cmd <= 2'h3;
		want <= 6'h3f;
		repeat (7) @(posedge clk);
		#1 check({brk_un, pole_un}, {2'h3, 6'h3f});
		close_cmd <= 2'h0;
		repeat (12) @(posedge clk);
		#1 check({brk_ac, pole_cl, pole_fc}, {2'h3, 6'h3f, 6'h00});
		// open breaker 1 pole by pole
		for (int k = 1; k <= 3; k++) begin
			open_cmd <= 2'h1;
			want[2:0] <= 3'h7 << k;
			repeat (16) @(posedge clk);
			#1 check({brk_ao[0], brk_to[0], brk_oo[0]}, 1 << (k - 1));
		end
		open_cmd <= 2'h0;
		// short travel and 3 ms limits, then a pole jammed closed
		travel <= 4'h1;
		wr(ADDR_MAX_OPEN, 32'h3);
		wr(ADDR_MAX_CLOSE, 32'h3);
		stuck <= 6'h08;
		open_cmd <= 2'h2;
		want[5:3] <= 3'h0;
		repeat (6) @(posedge clk);
		#1 check(pole_fo, 6'h00);
		repeat (40) if (pole_fo[3] !== 1'b1) @(posedge clk);
		#1 check({brk_fo, pole_fo}, {2'h2, 6'h08});
		stuck <= 6'h00;
		repeat (40) if (pole_fo[3] !== 1'b0) @(posedge clk);
		#1 check({brk_fo, pole_fo}, 8'h00);
		open_cmd <= 2'h0;
		// a pole jammed open while breaker 1 closes
		stuck <= 6'h01;
		close_cmd <= 2'h1;
		want[2:0] <= 3'h7;
		repeat (40) if (pole_fc[0] !== 1'b1) @(posedge clk);
		#1 check({brk_fc, pole_fc}, {2'h1, 6'h01});
		stuck <= 6'h00;
		repeat (40) if (pole_fc[0] !== 1'b0) @(posedge clk);
		#1 check({brk_fc, pole_fc, pole_cl}, {2'h0, 6'h00, 6'h07});
		close_cmd <= 2'h0;
		// second reset in mid-run clears the flags
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		#1 check({comm_trigger, pole_cl, brk_ac}, 9'h000);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1 check(table_active, 3'h1);
		tally_and_finish();
	end
endmodule : tb_top
